// ### bench/tb_adcc_ctrl.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
module tb_adcc_ctrl
  import adcc_pkg::*;
;
  logic sys_clk;
  logic rst_n;
  adcc_bus_t bus;
  logic [DATA_W-1:0] rd_data;
  logic [9:0] conv_result;
  logic [DATA_W-1:0] irq_event;
  adcc_cfg_t cfg;
  logic irq;
  int n_fail = 0;
  int n_compared = 0;
  integer seed = 78;
  logic [7:0] m_c1 = 8'h00, m_c2 = 8'h00, m_ie = 8'h00, m_st = 8'h00;
  logic m_oen = 1'b0;
  logic [9:0] m_res = 10'h000;
  logic [15:0] addrs [8] = '{ADDR_CTRL1, ADDR_CTRL2, ADDR_DATA0, ADDR_DATA1, ADDR_IE, ADDR_ISTAT,
                             ADDR_IOEN, 16'h05FF};

  adcc_ctrl #(.RES_W(10)) i_adcc_ctrl (.sys_clk(sys_clk), .rst_n(rst_n), .bus(bus),
    .rd_data(rd_data), .conv_result(conv_result), .irq_event(irq_event), .cfg(cfg), .irq(irq));

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic close_out();
    if (n_fail == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : close_out

  function automatic logic [7:0] mrd(input logic [15:0] a);
    case (a)
      ADDR_CTRL1: return m_c1;
      ADDR_CTRL2: return m_c2;
      ADDR_DATA0: return m_res[7:0];
      ADDR_DATA1: return {6'h00, m_res[9:8]};
      ADDR_IE: return m_ie;
      ADDR_ISTAT: return m_st;
      ADDR_IOEN: return {7'h00, m_oen};
      default: return RD_ZERO;
    endcase
  endfunction : mrd

  task automatic outs();
    chk({6'h00, cfg}, {6'h00, m_c1[7:4], m_c1[2:1], m_c2[3:0]});
    chk({15'h0000, irq}, {15'h0000, m_oen & (|(m_st & m_ie))});
  endtask : outs
  ////////////////////////////////////////////////////////////////
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    bus.wr <= 1'b0;
    case (a)
      ADDR_CTRL1: m_c1 = d & 8'hF6;
      ADDR_CTRL2: m_c2 = d & 8'h0F;
      ADDR_IE: m_ie = d & IRQ_USED;
      ADDR_ISTAT: m_st = m_st & ~d;
      ADDR_IOEN: m_oen = d[OEN_BIT];
      default: ;
    endcase
    #1 outs();
    @(posedge sys_clk);
  endtask : wr

  task automatic rd(input logic [15:0] a);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    bus.rd <= 1'b0;
    #1 chk({8'h00, rd_data}, {8'h00, mrd(a)});
    @(posedge sys_clk);
    #1 chk({8'h00, rd_data}, 16'h0000);
  endtask : rd

  task automatic ev(input logic [7:0] b, input logic [9:0] r);
    irq_event <= b;
    conv_result <= r;
    @(posedge sys_clk);
    irq_event <= 8'h00;
    m_st = m_st | (b & IRQ_USED);
    if (b[IRQ_DONE]) m_res = r;
    #1 outs();
    @(posedge sys_clk);
  endtask : ev
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_fail++;
    close_out();
  end

  initial begin
    rst_n = 1'b0;
    bus = '0;
    conv_result = 10'h000;
    irq_event = 8'h00;
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    #1 outs();
    foreach (addrs[i]) rd(addrs[i]);
    for (int i = 0; i < 8; i++) begin
      wr(ADDR_CTRL1, (8'($random(seed)) & 8'hF0) | {5'h00, i[1:0], 1'b0});
      wr(ADDR_CTRL2, (8'($random(seed)) & 8'hF3) | {4'h0, i[2:1], 2'h0});
      rd(ADDR_CTRL1);
      rd(ADDR_CTRL2);
    end
    for (int j = 0; j < 24; j++) begin
      wr(ADDR_IE, 8'($random(seed)));
      wr(ADDR_IOEN, 8'($random(seed)));
      ev(8'($random(seed)), 10'($random(seed)));
      wr(ADDR_DATA0, 8'($random(seed)));
      wr(ADDR_DATA1, 8'($random(seed)));
      rd(ADDR_DATA0);
      rd(ADDR_DATA1);
      rd(ADDR_ISTAT);
      rd(ADDR_IE);
      rd(ADDR_IOEN);
      wr(ADDR_ISTAT, 8'($random(seed)));
    end
    for (int k = 0; k < 4; k++) begin
      wr(ADDR_ISTAT, 8'hFF);
      wr(ADDR_IE, 8'h01 << k);
      wr(ADDR_IOEN, 8'h01);
      ev(8'h0F & ~(8'h01 << k), 10'($random(seed)));
      ev(8'h01 << k, 10'($random(seed)));
      wr(ADDR_IOEN, 8'h00);
    end
    // Event and status clear on the same edge
    wr(ADDR_IOEN, 8'h01);
    bus <= '{addr: ADDR_ISTAT, wdata: 8'hFF, wr: 1'b1, rd: 1'b0};
    irq_event <= 8'h09;
    conv_result <= 10'h2A5;
    @(posedge sys_clk);
    bus.wr <= 1'b0;
    irq_event <= 8'h00;
    m_st = 8'h09;
    m_res = 10'h2A5;
    #1 outs();
    rd(ADDR_ISTAT);
    rd(ADDR_DATA0);
    rd(ADDR_DATA1);
    close_out();
  end
endmodule : tb_adcc_ctrl
`default_nettype wire

// ### verilog/adcc_ctrl.sv
// Converter control, result readback and interrupt logic
`timescale 1ns/1ps
`default_nettype none

// Function
// - The reference-select bit picks the bandgap or external reference at 0 and half supply at 1.
// - The scale bit leaves the input unscaled at 0 and halves it at 1.
// - The two-bit divider field divides the input by 1, 2, 3 or 4 for codes 0 to 3.
// - The low eight result bits read back read-only in the first result register, reset zero.
// - The top two result bits read back read-only in bits 1:0 of the second result register.
// - Each interrupt-enable bit except bit 4, which always stays 0, disables its source at 0 and enables it at 1, resetting to 0.
// - Enable bits 0 to 3 serve conversion done, reference ready, high limit and low limit.
// - A source reaches the interrupt output only while the global output enable is also set.
// - The four-bit channel-select field picks the analog input for the next conversion.
module adcc_ctrl
  import adcc_pkg::*;
#(
  parameter int RES_W = RES_W_DEF
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire adcc_bus_t bus,
  output logic [DATA_W-1:0] rd_data,
  input wire logic [RES_W-1:0] conv_result,
  input wire logic [DATA_W-1:0] irq_event,
  output adcc_cfg_t cfg,
  output logic irq
);

  if (RES_W <= RES_LO_W || RES_W > 2 * RES_LO_W) begin : g_bad_width
    $error("adcc_ctrl: RES_W must lie between 9 and 16");
  end

  ////////////////////////////////////////////////////////////////
  // State
  adcc_cfg_t cfg_q;
  adcc_cfg_t cfg_d;
  logic [DATA_W-1:0] ie_q;
  logic [DATA_W-1:0] ie_d;
  logic [DATA_W-1:0] stat_q;
  logic [DATA_W-1:0] stat_d;
  logic oen_q;
  logic oen_d;
  logic [RES_W-1:0] res_q;
  logic [RES_W-1:0] res_d;
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rdata_d;
  logic irq_q;
  logic irq_d;
  logic [DATA_W-1:0] evt;
  logic conv_done;

  assign evt = irq_event & IRQ_USED;
  assign conv_done = irq_event[IRQ_DONE];

  ////////////////////////////////////////////////////////////////
  // Configuration registers
  always_comb begin
    cfg_d = cfg_q;
    if (bus.wr && bus.addr == ADDR_CTRL1) begin
      cfg_d.chsel = bus.wdata[CHSEL_MSB:CHSEL_LSB];
      cfg_d.refsel = adcc_ref_t'(bus.wdata[REFSEL_BIT]);
      cfg_d.scale = bus.wdata[SCALE_BIT];
    end
    if (bus.wr && bus.addr == ADDR_CTRL2) begin
      cfg_d.div = adcc_div_t'(bus.wdata[DIV_MSB:DIV_LSB]);
      cfg_d.xref = bus.wdata[XREF_BIT];
      cfg_d.inmux_en = bus.wdata[INMUX_BIT];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cfg_q <= '0;
    end else begin
      cfg_q <= cfg_d;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Interrupt enable, status and output enable
  always_comb begin
    ie_d = ie_q;
    oen_d = oen_q;
    stat_d = stat_q | evt;
    if (bus.wr && bus.addr == ADDR_IE) begin
      ie_d = bus.wdata & IRQ_USED;
    end
    if (bus.wr && bus.addr == ADDR_IOEN) begin
      oen_d = bus.wdata[OEN_BIT];
    end
    if (bus.wr && bus.addr == ADDR_ISTAT) begin
      // Set beats clear in the same cycle
      stat_d = (stat_q & ~bus.wdata) | evt;
    end
    irq_d = oen_d && |(stat_d & ie_d);
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ie_q <= REG_RST;
      stat_q <= REG_RST;
      oen_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      ie_q <= ie_d;
      stat_q <= stat_d;
      oen_q <= oen_d;
      irq_q <= irq_d;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Result capture, read only from the bus
  always_comb begin
    res_d = res_q;
    if (conv_done) begin
      res_d = conv_result;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      res_q <= '0;
    end else begin
      res_q <= res_d;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Read data, one cycle after the strobe
  always_comb begin
    rdata_d = RD_ZERO;
    if (bus.rd) begin
      case (bus.addr)
        ADDR_CTRL1: begin
          rdata_d[CHSEL_MSB:CHSEL_LSB] = cfg_q.chsel;
          rdata_d[REFSEL_BIT] = cfg_q.refsel;
          rdata_d[SCALE_BIT] = cfg_q.scale;
        end
        ADDR_CTRL2: begin
          rdata_d[DIV_MSB:DIV_LSB] = cfg_q.div;
          rdata_d[XREF_BIT] = cfg_q.xref;
          rdata_d[INMUX_BIT] = cfg_q.inmux_en;
        end
        ADDR_DATA0: begin
          rdata_d = res_q[RES_LO_W-1:0];
        end
        ADDR_DATA1: begin
          rdata_d = DATA_W'(res_q >> RES_LO_W);
        end
        ADDR_IE: begin
          rdata_d = ie_q;
        end
        ADDR_ISTAT: begin
          rdata_d = stat_q;
        end
        ADDR_IOEN: begin
          rdata_d[OEN_BIT] = oen_q;
        end
        default: begin
          rdata_d = RD_ZERO;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rdata_q <= RD_ZERO;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign rd_data = rdata_q;
  assign cfg = cfg_q;
  assign irq = irq_q;

  ////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  a_refsel_write: assert property (
    bus.wr && bus.addr == ADDR_CTRL1
    |=> cfg.refsel == $past(bus.wdata[REFSEL_BIT])
  ) else $error("reference select not taken from write");

  a_scale_write: assert property (
    bus.wr && bus.addr == ADDR_CTRL1
    |=> cfg.scale == $past(bus.wdata[SCALE_BIT])
  ) else $error("scale bit not taken from write");

  a_div_write: assert property (
    bus.wr && bus.addr == ADDR_CTRL2
    |=> cfg.div == $past(bus.wdata[DIV_MSB:DIV_LSB])
  ) else $error("divider code not taken from write");

  a_data_low_read: assert property (
    bus.rd && bus.addr == ADDR_DATA0
    |=> rd_data == $past(res_q[RES_LO_W-1:0])
  ) else $error("low result byte read wrong");

  a_data_high_read: assert property (
    bus.rd && bus.addr == ADDR_DATA1
    |=> rd_data == DATA_W'($past(res_q) >> RES_LO_W)
  ) else $error("high result bits read wrong");

  a_ie_disable: assert property (
    ie_q == REG_RST |-> !irq
  ) else $error("disabled sources raised the interrupt");

  a_hi_limit_irq: assert property (
    irq_event[IRQ_HI_LIMIT] && ie_d[IRQ_HI_LIMIT] && oen_d
    |=> irq && stat_q[IRQ_HI_LIMIT]
  ) else $error("high limit event did not interrupt");

  a_oen_gate: assert property (
    !oen_q |-> !irq
  ) else $error("interrupt without global output enable");

  a_chsel_hold: assert property (
    !(bus.wr && bus.addr == ADDR_CTRL1) |=> $stable(cfg.chsel)
  ) else $error("channel select changed without write");

  a_result_hold: assert property (
    !conv_done |=> $stable(res_q)
  ) else $error("result changed without conversion done");

  a_result_load: assert property (
    conv_done |=> res_q == $past(conv_result)
  ) else $error("result not captured on conversion done");

  a_set_wins: assert property (
    irq_event[IRQ_DONE] && bus.wr && bus.addr == ADDR_ISTAT
    |=> stat_q[IRQ_DONE]
  ) else $error("event lost under status clear");

  a_xref_write: assert property (
    bus.wr && bus.addr == ADDR_CTRL2
    |=> cfg.xref == $past(bus.wdata[XREF_BIT])
  ) else $error("external reference bit not taken from write");

  a_chsel_write: assert property (
    bus.wr && bus.addr == ADDR_CTRL1
    |=> cfg.chsel == $past(bus.wdata[CHSEL_MSB:CHSEL_LSB])
  ) else $error("channel select not taken from write");

  a_ie_write: assert property (
    bus.wr && bus.addr == ADDR_IE
    |=> ie_q == $past(bus.wdata & IRQ_USED)
  ) else $error("interrupt enable not taken from write");

  a_ie_gate: assert property (
    irq
    |-> (stat_q & ie_q) != REG_RST
  ) else $error("interrupt without an enabled pending source");

  a_lo_limit_irq: assert property (
    irq_event[IRQ_LO_LIMIT] && ie_d[IRQ_LO_LIMIT] && oen_d
    |=> irq && stat_q[IRQ_LO_LIMIT]
  ) else $error("low limit event did not interrupt");

  a_done_irq: assert property (
    irq_event[IRQ_DONE] && ie_d[IRQ_DONE] && oen_d
    |=> irq && stat_q[IRQ_DONE]
  ) else $error("conversion done event did not interrupt");

  a_ref_ready_irq: assert property (
    irq_event[IRQ_REF_READY] && ie_d[IRQ_REF_READY] && oen_d
    |=> irq && stat_q[IRQ_REF_READY]
  ) else $error("reference ready event did not interrupt");

  a_oen_write: assert property (
    bus.wr && bus.addr == ADDR_IOEN
    |=> oen_q == $past(bus.wdata[OEN_BIT])
  ) else $error("output enable not taken from write");

  a_result_ro: assert property (
    bus.wr && (bus.addr == ADDR_DATA0 || bus.addr == ADDR_DATA1) && !conv_done
    |=> $stable(res_q)
  ) else $error("result changed by a bus write");

  a_ie_read: assert property (
    bus.rd && bus.addr == ADDR_IE
    |=> rd_data == $past(ie_q)
  ) else $error("interrupt enable read wrong");

  a_div_read: assert property (
    bus.rd && bus.addr == ADDR_CTRL2
    |=> rd_data[DIV_MSB:DIV_LSB] == $past(cfg_q.div)
  ) else $error("divider code read wrong");

  a_rdata_idle: assert property (
    !bus.rd
    |=> rd_data == RD_ZERO
  ) else $error("read data not zero outside a read");

  a_stat_clear: assert property (
    bus.wr && bus.addr == ADDR_ISTAT && bus.wdata[IRQ_DONE] && !irq_event[IRQ_DONE]
    |=> !stat_q[IRQ_DONE]
  ) else $error("status bit not cleared by a one");

endmodule : adcc_ctrl

`default_nettype wire

// ### verilog/adcc_pkg.sv
// Constants and carrier types for the converter control block
package adcc_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int RES_W_DEF = 10;
  localparam int RES_LO_W = 8;
  ////////////////////////////////////////////////////////////////
  localparam logic [ADDR_W-1:0] ADDR_CTRL1 = 16'h0501;
  localparam logic [ADDR_W-1:0] ADDR_CTRL2 = 16'h0502;
  localparam logic [ADDR_W-1:0] ADDR_DATA0 = 16'h0508;
  localparam logic [ADDR_W-1:0] ADDR_DATA1 = 16'h0509;
  localparam logic [ADDR_W-1:0] ADDR_IE = 16'h050C;
  localparam logic [ADDR_W-1:0] ADDR_ISTAT = 16'h0510;
  localparam logic [ADDR_W-1:0] ADDR_IOEN = 16'h0511;
  ////////////////////////////////////////////////////////////////
  localparam int CHSEL_LSB = 4;
  localparam int CHSEL_MSB = 7;
  localparam int REFSEL_BIT = 2;
  localparam int SCALE_BIT = 1;
  localparam int DIV_LSB = 2;
  localparam int DIV_MSB = 3;
  localparam int XREF_BIT = 1;
  localparam int INMUX_BIT = 0;
  localparam int OEN_BIT = 0;
  ////////////////////////////////////////////////////////////////
  localparam int IRQ_DONE = 0;
  localparam int IRQ_REF_READY = 1;
  localparam int IRQ_HI_LIMIT = 2;
  localparam int IRQ_LO_LIMIT = 3;
  localparam int IRQ_TEMP_OOD = 5;
  localparam int IRQ_OVER_RANGE = 6;
  localparam int IRQ_CAL_DONE = 7;
  localparam logic [DATA_W-1:0] IRQ_USED = 8'hEF;
  localparam logic [DATA_W-1:0] REG_RST = 8'h00;
  localparam logic [DATA_W-1:0] RD_ZERO = 8'h00;
  ////////////////////////////////////////////////////////////////
  typedef enum logic {
    REF_BANDGAP = 1'b0,
    REF_HALF_SUPPLY = 1'b1
  } adcc_ref_t;
  typedef enum logic [1:0] {
    DIV_BY1 = 2'h0,
    DIV_BY2 = 2'h1,
    DIV_BY3 = 2'h2,
    DIV_BY4 = 2'h3
  } adcc_div_t;
  typedef struct packed {
    logic [3:0] chsel;
    adcc_ref_t refsel;
    logic scale;
    adcc_div_t div;
    logic xref;
    logic inmux_en;
  } adcc_cfg_t;
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } adcc_bus_t;
endpackage : adcc_pkg
